// ==== rtl/mailbox_pkg.sv ====
// constants for the host-to-processor mailbox port.
// assumes one processor clock domain; no other package is needed.
package mailbox_pkg;

  // local processor i/o addresses
  localparam logic [7:0] ADDR_DATA0 = 8'h20;
  localparam logic [7:0] ADDR_DATA1 = 8'h21;
  localparam logic [7:0] ADDR_DATA2 = 8'h22;
  localparam logic [7:0] ADDR_FLAGS = 8'h23;
  localparam logic [7:0] ADDR_CTRL  = 8'h24;

  // master-side register select values
  localparam logic [1:0] SEL_DATA0 = 2'h0;
  localparam logic [1:0] SEL_FLAGS = 2'h3;

  // number of data registers in each direction
  localparam int NUM_DATA = 3;

  // control register field positions
  localparam int CTL_IGNORE_BOOT = 7;
  localparam int CTL_PIN1        = 6;
  localparam int CTL_PIN0        = 5;
  localparam int CTL_MODE_HI     = 3;
  localparam int CTL_MODE_LO     = 2;
  localparam int CTL_PRIO_HI     = 1;
  localparam int CTL_PRIO_LO     = 0;

  // port function codes held in control bits 3:2
  localparam logic [1:0] MODE_PA_IN   = 2'h0;
  localparam logic [1:0] MODE_PA_OUT  = 2'h1;
  localparam logic [1:0] MODE_MAILBOX = 2'h2;
  localparam logic [1:0] MODE_AUX     = 2'h3;

  // interrupt priority code meaning disabled
  localparam logic [1:0] PRIO_OFF = 2'h0;

  // status register field positions
  localparam int FLG_M_DATA0_INT = 7;
  localparam int FLG_M_FULL_BASE = 4;
  localparam int FLG_P_DATA0_ATN = 3;
  localparam int FLG_P_FULL_BASE = 0;

  // boot-mode pin codes as {pin1, pin0}
  localparam logic [1:0] PINS_COLD  = 2'h1;
  localparam logic [1:0] PINS_START = 2'h0;

  // reset values
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic [1:0] PRIO_RST   = 2'h0;
  localparam logic       IGNORE_RST = 1'b0;

  // pin synchroniser reset, select and strobes idle high, the rest low;
  // a zero here would read as an open access when reset ends
  localparam logic [14:0] SYNC_RST = 15'h7000;

  // cycles the pin synchroniser needs before a strap is valid
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef enum logic [1:0] {
    BOOT_CHECK = 2'b00,
    BOOT_LOAD  = 2'b01,
    BOOT_RUN   = 2'b11
  } boot_state_t;

endpackage

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser for a group of asynchronous pins.
// assumes the pins change slowly against the clock; bits are not coherent.
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RST_VAL;  // idle level of each pin
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ==== rtl/slave_port_mailbox.sv ====
// mailbox port between an external strobed-bus master and the local cpu.
// assumes the cpu i/o bus is synchronous to CLK with one-cycle strobes,
// and the master bus pins and boot-mode pins are asynchronous.
`timescale 1ns/1ps

// Contract
// - each data address holds a master-to-cpu byte and a cpu-to-master byte
// - cpu sees data, status, control at 20h..24h, control at 24h
// - master selects data 0..2 and status by select 0..3; no control
// - cpu-written registers are read only by master, and the reverse
// - polled bits move once old to new; mixed value on one read at most
// - control bit 7 write-only: 0 obeys boot pins, 1 ignores them
// - boot pins 01 at reset end start cold boot via data register 0
// - boot pins changed to 00 end cold boot; execution starts at zero
// - control bits 6:5 read boot pins pin1, pin0
// - control bits 3:2 = 10 enable the mailbox port over port A
// - bit 3 = 0 disables mailbox; bit 2 sets port A direction; code only drops PORT_ENABLE, master accesses still served
// - control bits 3:2 = 11 enable the auxiliary i/o bus
// - cold boot forces control bits 3:2 to 10
// - control bits 1:0 give interrupt priority, 00 disables
// - status 6:4 master-write full, 2:0 cpu-write full, cleared on read
// - status 7 interrupt and 3 attention flags, cleared by status writes
// - attention low on cpu data 0 write, high on master status write
// - status writes ignore data, clear only that side's request flag
// - drive data only while select and read low; capture on first rise
module slave_port_mailbox (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic [7:0] IO_ADDR,
  input  wire logic       IO_WR,
  input  wire logic       IO_RD,
  input  wire logic [7:0] IO_WDATA,
  output logic      [7:0] IO_RDATA,
  input  wire logic       PORT_SELECT_N,
  input  wire logic       PORT_READ_N,
  input  wire logic       PORT_WRITE_N,
  input  wire logic       REG_SELECT0,
  input  wire logic       REG_SELECT1,
  input  wire logic [7:0] PORT_DATA_BUS_IN,
  output logic      [7:0] PORT_DATA_BUS_OUT,
  output logic            PORT_DATA_BUS_OE,
  output logic            ATTENTION_N,
  input  wire logic       BOOT_MODE_PIN0,
  input  wire logic       BOOT_MODE_PIN1,
  output logic            INT_REQUEST,
  output logic      [1:0] INT_PRIORITY,
  output logic            PORT_ENABLE,
  output logic            PORT_A_OUTPUT,
  output logic            AUX_BUS_ENABLE,
  output logic            BOOT_PINS_IGNORED,
  output logic            COLD_BOOT_ACTIVE,
  output logic            BOOT_CMD_VALID,
  output logic      [7:0] BOOT_CMD_DATA,
  output logic            EXEC_START
);

  localparam int N = mailbox_pkg::NUM_DATA;

  // synchronised pins
  logic       s_sel_n;
  logic       s_rd_n;
  logic       s_wr_n;
  logic [1:0] s_addr;
  logic [7:0] s_data;
  logic [1:0] s_pins;

  pin_sync #(
    .WIDTH   (15),
    .RST_VAL (mailbox_pkg::SYNC_RST)
  ) u_sync (
    .clk  (CLK),
    .rstn (RSTN),
    .d    ({PORT_SELECT_N, PORT_READ_N, PORT_WRITE_N, REG_SELECT1,
            REG_SELECT0, PORT_DATA_BUS_IN, BOOT_MODE_PIN1,
            BOOT_MODE_PIN0}),
    .q    ({s_sel_n, s_rd_n, s_wr_n, s_addr, s_data, s_pins})
  );

  // master bus tracking state
  logic       m_wr_act_reg, m_wr_act_next;
  logic       m_rd_act_reg, m_rd_act_next;
  logic [1:0] m_addr_reg,   m_addr_next;
  logic [7:0] m_data_reg,   m_data_next;
  logic       m_wr_done;
  logic       m_rd_done;

  // mailbox storage and flags
  logic [7:0] to_cpu_reg    [N];
  logic [7:0] to_cpu_next   [N];
  logic [7:0] to_master_reg [N];
  logic [7:0] to_master_next[N];
  logic [7:0] flags_reg,  flags_next;

  // control fields
  logic       ignore_reg, ignore_next;
  logic [1:0] mode_reg,   mode_next;
  logic [1:0] prio_reg,   prio_next;

  // boot sequencing
  mailbox_pkg::boot_state_t boot_reg, boot_next;
  logic [1:0] wait_reg,   wait_next;
  logic       exec_next;
  logic       cmd_valid_next;

  // output registers
  logic [7:0] io_rdata_next;
  logic [7:0] bus_out_next;
  logic       bus_oe_next;
  logic       attn_n_next;
  logic       int_req_next;

  // cpu-side decode
  logic       p_wr_flags;
  logic       p_wr_ctrl;
  logic [N-1:0] p_wr_data;
  logic [N-1:0] p_rd_data;

  // master access detection: write ends when strobe or select rises
  always_comb begin
    m_wr_act_next = !s_sel_n && !s_wr_n;
    m_rd_act_next = !s_sel_n && !s_rd_n;
    m_addr_next   = m_addr_reg;
    m_data_next   = m_data_reg;
    if (m_wr_act_next || m_rd_act_next) begin
      m_addr_next = s_addr;
    end
    // keep the last sampled data seen while the write was open
    if (m_wr_act_next) begin
      m_data_next = s_data;
    end
    m_wr_done = m_wr_act_reg && !m_wr_act_next;
    m_rd_done = m_rd_act_reg && !m_rd_act_next;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      m_wr_act_reg <= 1'b0;
      m_rd_act_reg <= 1'b0;
      m_addr_reg   <= 2'h0;
      m_data_reg   <= mailbox_pkg::DATA_RST;
    end else begin
      m_wr_act_reg <= m_wr_act_next;
      m_rd_act_reg <= m_rd_act_next;
      m_addr_reg   <= m_addr_next;
      m_data_reg   <= m_data_next;
    end
  end

  // cpu address decode, one word per internal address
  always_comb begin
    p_wr_flags = IO_WR && (IO_ADDR == mailbox_pkg::ADDR_FLAGS);
    p_wr_ctrl  = IO_WR && (IO_ADDR == mailbox_pkg::ADDR_CTRL);
    for (int i = 0; i < N; i++) begin
      p_wr_data[i] = IO_WR &&
        (IO_ADDR == mailbox_pkg::ADDR_DATA0 + 8'(i));
      p_rd_data[i] = IO_RD &&
        (IO_ADDR == mailbox_pkg::ADDR_DATA0 + 8'(i));
    end
  end

  // data bytes and full flags; a set in the same cycle beats a clear
  always_comb begin
    flags_next = flags_reg;
    for (int i = 0; i < N; i++) begin
      to_cpu_next[i]    = to_cpu_reg[i];
      to_master_next[i] = to_master_reg[i];
      // separate bytes per direction, so neither side sees its own write
      if (m_wr_done && (m_addr_reg == 2'(i))) begin
        to_cpu_next[i] = m_data_reg;
      end
      if (p_wr_data[i]) begin
        to_master_next[i] = IO_WDATA;
      end
      // clears first, sets after
      if (p_rd_data[i]) begin
        flags_next[mailbox_pkg::FLG_M_FULL_BASE + i] = 1'b0;
      end
      if (m_rd_done && (m_addr_reg == 2'(i))) begin
        flags_next[mailbox_pkg::FLG_P_FULL_BASE + i] = 1'b0;
      end
      if (m_wr_done && (m_addr_reg == 2'(i))) begin
        flags_next[mailbox_pkg::FLG_M_FULL_BASE + i] = 1'b1;
      end
      if (p_wr_data[i]) begin
        flags_next[mailbox_pkg::FLG_P_FULL_BASE + i] = 1'b1;
      end
    end
    // status writes drop only the writer's own request flag
    if (p_wr_flags) begin
      flags_next[mailbox_pkg::FLG_M_DATA0_INT] = 1'b0;
    end
    if (m_wr_done && (m_addr_reg == mailbox_pkg::SEL_FLAGS)) begin
      flags_next[mailbox_pkg::FLG_P_DATA0_ATN] = 1'b0;
    end
    if (m_wr_done && (m_addr_reg == mailbox_pkg::SEL_DATA0)) begin
      flags_next[mailbox_pkg::FLG_M_DATA0_INT] = 1'b1;
    end
    if (p_wr_data[0]) begin
      flags_next[mailbox_pkg::FLG_P_DATA0_ATN] = 1'b1;
    end
    // status reads touch nothing
    attn_n_next  = !flags_next[mailbox_pkg::FLG_P_DATA0_ATN];
    int_req_next = flags_next[mailbox_pkg::FLG_M_DATA0_INT] &&
                   (prio_next != mailbox_pkg::PRIO_OFF);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < N; i++) begin
        to_cpu_reg[i]    <= mailbox_pkg::DATA_RST;
        to_master_reg[i] <= mailbox_pkg::DATA_RST;
      end
      flags_reg   <= mailbox_pkg::FLAGS_RST;
      ATTENTION_N <= 1'b1;
      INT_REQUEST <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        to_cpu_reg[i]    <= to_cpu_next[i];
        to_master_reg[i] <= to_master_next[i];
      end
      flags_reg   <= flags_next;
      ATTENTION_N <= attn_n_next;
      INT_REQUEST <= int_req_next;
    end
  end

  // control register and boot sequencer
  always_comb begin
    ignore_next    = ignore_reg;
    mode_next      = mode_reg;
    prio_next      = prio_reg;
    boot_next      = boot_reg;
    wait_next      = wait_reg;
    exec_next      = 1'b0;
    cmd_valid_next = 1'b0;
    if (p_wr_ctrl) begin
      // bit 4 and the read-only pin bits are dropped
      ignore_next = IO_WDATA[mailbox_pkg::CTL_IGNORE_BOOT];
      mode_next   = IO_WDATA[mailbox_pkg::CTL_MODE_HI:
                             mailbox_pkg::CTL_MODE_LO];
      prio_next   = IO_WDATA[mailbox_pkg::CTL_PRIO_HI:
                             mailbox_pkg::CTL_PRIO_LO];
    end
    case (boot_reg)
      mailbox_pkg::BOOT_CHECK: begin
        // strap is read only after the synchroniser has filled
        if (wait_reg == mailbox_pkg::STRAP_WAIT) begin
          if (!ignore_next && (s_pins == mailbox_pkg::PINS_COLD)) begin
            boot_next = mailbox_pkg::BOOT_LOAD;
            mode_next = mailbox_pkg::MODE_MAILBOX;
          end else begin
            boot_next = mailbox_pkg::BOOT_RUN;
          end
        end else begin
          wait_next = wait_reg + 2'h1;
        end
      end
      mailbox_pkg::BOOT_LOAD: begin
        mode_next = mailbox_pkg::MODE_MAILBOX;
        // loader commands arrive through data register 0
        cmd_valid_next = m_wr_done &&
                         (m_addr_reg == mailbox_pkg::SEL_DATA0);
        if (!ignore_next && (s_pins == mailbox_pkg::PINS_START)) begin
          boot_next = mailbox_pkg::BOOT_RUN;
          exec_next = 1'b1;
        end
      end
      default: begin
        boot_next = mailbox_pkg::BOOT_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ignore_reg        <= mailbox_pkg::IGNORE_RST;
      mode_reg          <= mailbox_pkg::MODE_RST;
      prio_reg          <= mailbox_pkg::PRIO_RST;
      boot_reg          <= mailbox_pkg::BOOT_CHECK;
      wait_reg          <= 2'h0;
      EXEC_START        <= 1'b0;
      BOOT_CMD_VALID    <= 1'b0;
      BOOT_CMD_DATA     <= mailbox_pkg::DATA_RST;
      COLD_BOOT_ACTIVE  <= 1'b0;
      PORT_ENABLE       <= 1'b0;
      PORT_A_OUTPUT     <= 1'b0;
      AUX_BUS_ENABLE    <= 1'b0;
      INT_PRIORITY      <= mailbox_pkg::PRIO_RST;
      BOOT_PINS_IGNORED <= mailbox_pkg::IGNORE_RST;
    end else begin
      ignore_reg        <= ignore_next;
      mode_reg          <= mode_next;
      prio_reg          <= prio_next;
      boot_reg          <= boot_next;
      wait_reg          <= wait_next;
      EXEC_START        <= exec_next;
      BOOT_CMD_VALID    <= cmd_valid_next;
      BOOT_CMD_DATA     <= m_data_reg;
      COLD_BOOT_ACTIVE  <= (boot_next == mailbox_pkg::BOOT_LOAD);
      PORT_ENABLE       <= (mode_next == mailbox_pkg::MODE_MAILBOX);
      PORT_A_OUTPUT     <= (mode_next == mailbox_pkg::MODE_PA_OUT);
      AUX_BUS_ENABLE    <= (mode_next == mailbox_pkg::MODE_AUX);
      INT_PRIORITY      <= prio_next;
      BOOT_PINS_IGNORED <= ignore_next;
    end
  end

  // read paths; registered so every bit settles once per cycle
  always_comb begin
    io_rdata_next = 8'h00;
    if (IO_ADDR == mailbox_pkg::ADDR_DATA0) begin
      io_rdata_next = to_cpu_reg[0];
    end else if (IO_ADDR == mailbox_pkg::ADDR_DATA1) begin
      io_rdata_next = to_cpu_reg[1];
    end else if (IO_ADDR == mailbox_pkg::ADDR_DATA2) begin
      io_rdata_next = to_cpu_reg[2];
    end else if (IO_ADDR == mailbox_pkg::ADDR_FLAGS) begin
      io_rdata_next = flags_reg;
    end else if (IO_ADDR == mailbox_pkg::ADDR_CTRL) begin
      io_rdata_next[mailbox_pkg::CTL_PIN1] = s_pins[1];
      io_rdata_next[mailbox_pkg::CTL_PIN0] = s_pins[0];
    end
    // master never reaches the control register
    if (s_addr == mailbox_pkg::SEL_FLAGS) begin
      bus_out_next = flags_reg;
    end else begin
      bus_out_next = to_master_reg[s_addr];
    end
    // drive only while select and read strobe are both low
    bus_oe_next = m_rd_act_next;
  end

  // one register stage keeps polled values free of glitches
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      IO_RDATA          <= 8'h00;
      PORT_DATA_BUS_OUT <= 8'h00;
      PORT_DATA_BUS_OE  <= 1'b0;
    end else begin
      IO_RDATA          <= io_rdata_next;
      PORT_DATA_BUS_OUT <= bus_out_next;
      PORT_DATA_BUS_OE  <= bus_oe_next;
    end
  end

  property p_attn_low;
    @(posedge CLK) disable iff (!RSTN)
    p_wr_data[0] |=> !ATTENTION_N;
  endproperty
  a_attn_low: assert property (p_attn_low)
    else $error("attention not low after cpu data 0 write");

  property p_attn_high;
    @(posedge CLK) disable iff (!RSTN)
    (m_wr_done && m_addr_reg == mailbox_pkg::SEL_FLAGS && !p_wr_data[0])
      |=> ATTENTION_N && !flags_reg[mailbox_pkg::FLG_P_DATA0_ATN];
  endproperty
  a_attn_high: assert property (p_attn_high)
    else $error("attention not released by master status write");

  property p_int_set;
    @(posedge CLK) disable iff (!RSTN)
    (m_wr_done && m_addr_reg == mailbox_pkg::SEL_DATA0)
      |=> flags_reg[mailbox_pkg::FLG_M_DATA0_INT]
          && flags_reg[mailbox_pkg::FLG_M_FULL_BASE];
  endproperty
  a_int_set: assert property (p_int_set)
    else $error("master data 0 write did not set its flags");

  property p_int_clear;
    @(posedge CLK) disable iff (!RSTN)
    (p_wr_flags && !(m_wr_done && m_addr_reg == mailbox_pkg::SEL_DATA0))
      |=> !INT_REQUEST;
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt request survived cpu status write");

  property p_full_clear;
    @(posedge CLK) disable iff (!RSTN)
    (p_rd_data[1] && !(m_wr_done && m_addr_reg == 2'h1))
      |=> !flags_reg[mailbox_pkg::FLG_M_FULL_BASE + 1];
  endproperty
  a_full_clear: assert property (p_full_clear)
    else $error("cpu read of data 1 left its full flag set");

  property p_drive_window;
    @(posedge CLK) disable iff (!RSTN)
    PORT_DATA_BUS_OE == $past(!s_sel_n && !s_rd_n);
  endproperty
  a_drive_window: assert property (p_drive_window)
    else $error("data bus driven outside select and read window");

  property p_master_reads;
    @(posedge CLK) disable iff (!RSTN)
    (m_rd_act_next && s_addr == 2'h1)
      |=> PORT_DATA_BUS_OUT == $past(to_master_reg[1]);
  endproperty
  a_master_reads: assert property (p_master_reads)
    else $error("master read of data 1 returned wrong byte");

  property p_mode_write;
    @(posedge CLK) disable iff (!RSTN)
    (p_wr_ctrl && IO_WDATA[3:2] == mailbox_pkg::MODE_MAILBOX)
      |=> PORT_ENABLE && !AUX_BUS_ENABLE;
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mailbox port not enabled by control write");

  property p_cold_entry;
    @(posedge CLK) disable iff (!RSTN)
    (boot_reg == mailbox_pkg::BOOT_CHECK
      && boot_next == mailbox_pkg::BOOT_LOAD)
      |=> COLD_BOOT_ACTIVE && PORT_ENABLE;
  endproperty
  a_cold_entry: assert property (p_cold_entry)
    else $error("cold boot entry did not enable mailbox port");

  property p_exec_start;
    @(posedge CLK) disable iff (!RSTN)
    (boot_reg == mailbox_pkg::BOOT_LOAD && !ignore_next
      && s_pins == mailbox_pkg::PINS_START)
      |=> EXEC_START ##1 (!EXEC_START && !COLD_BOOT_ACTIVE);
  endproperty
  a_exec_start: assert property (p_exec_start)
    else $error("cold boot end did not give one start pulse");

endmodule

// ==== tb/master_model.sv ====
// strobed-bus master model for the mailbox port pins.
// assumes the port samples its strobes on clk; the bench calls wr and rd.
`timescale 1ns/1ps
module master_model (
  input  wire logic       clk,
  output logic            sel_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [1:0] rs,
  output logic      [7:0] bus_in,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe
);
  logic [7:0] drv;
  logic       drv_on;
  logic [7:0] last;

  // undriven lines flip every cycle so stale data never looks valid
  assign bus_in = bus_oe ? bus_out : (drv_on ? drv : ~last);

  always @(posedge clk) begin
    last <= bus_in;
  end

  initial begin
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    rs = 2'h0;
    drv = 8'h00;
    drv_on = 1'b0;
    last = 8'h00;
  end

  // one access at a time, spaced apart, never against a cpu write
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    rs = s;
    drv = d;
    drv_on = 1'b1;
    sel_n = 1'b0;
    wr_n = 1'b0;
    repeat (5) @(negedge clk);
    wr_n = 1'b1;
    sel_n = 1'b1;
    @(negedge clk);
    drv_on = 1'b0;
    repeat (5) @(negedge clk);
  endtask

  // data taken only while the port drives the lines
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(negedge clk);
    rs = s;
    sel_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(negedge clk);
    d = (bus_oe === 1'b1) ? bus_out : 8'hxx;
    rd_n = 1'b1;
    sel_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
endmodule

// ==== tb/tb_slave_port_mailbox.sv ====
// self-checking bench for the mailbox port and a strobed-bus master.
// assumes mailbox_pkg and master_model are compiled before it.
`timescale 1ns/1ps
module tb_slave_port_mailbox;
  typedef struct packed {
    logic [7:0] wr;
    logic [5:0] exp;
  } row_t;

  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       io_wr = 1'b0;
  logic       io_rd = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic       pin0 = 1'b0;
  logic       pin1 = 1'b0;
  logic [7:0] io_rdata, bus_in, bus_out, cmd_byte, cmd_data, rd_val;
  logic       sel_n, rd_n, wr_n, oe, attn_n, irq, pe, pao, aux, ign;
  logic       cold, cmd_v, exec;
  logic [1:0] rs, prio;
  int         n_errors = 0;
  int         n_compared = 0;
  int         n_exec = 0;
  int         cycles = 0;
  // control write, expected {ignore, port, pa_out, aux, priority}
  row_t       rows [5] = '{'{8'h00, 6'h00}, '{8'h05, 6'h09},
                           '{8'h0a, 6'h12}, '{8'h8f, 6'h27},
                           '{8'h10, 6'h00}};

  always #2.5 clk = ~clk;

  slave_port_mailbox i_dut (
    .CLK(clk), .RSTN(rstn), .IO_ADDR(io_addr), .IO_WR(io_wr),
    .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
    .PORT_SELECT_N(sel_n), .PORT_READ_N(rd_n), .PORT_WRITE_N(wr_n),
    .REG_SELECT0(rs[0]), .REG_SELECT1(rs[1]), .PORT_DATA_BUS_IN(bus_in),
    .PORT_DATA_BUS_OUT(bus_out), .PORT_DATA_BUS_OE(oe),
    .ATTENTION_N(attn_n), .BOOT_MODE_PIN0(pin0), .BOOT_MODE_PIN1(pin1),
    .INT_REQUEST(irq), .INT_PRIORITY(prio), .PORT_ENABLE(pe),
    .PORT_A_OUTPUT(pao), .AUX_BUS_ENABLE(aux), .BOOT_PINS_IGNORED(ign),
    .COLD_BOOT_ACTIVE(cold), .BOOT_CMD_VALID(cmd_v),
    .BOOT_CMD_DATA(cmd_byte), .EXEC_START(exec)
  );

  master_model u_m (
    .clk(clk), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .rs(rs),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(oe)
  );

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // loader pulses and hang guard; the run needs well under 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cmd_v === 1'b1) begin
      cmd_data <= cmd_byte;
    end
    if (exec === 1'b1) begin
      n_exec++;
    end
    if (cycles == 3000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input logic [7:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic cpu_wr(input logic [7:0] a, d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask

  task automatic cpu_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask

  // straps held across the whole reset and well past release
  task automatic do_reset(input logic [1:0] pins);
    @(negedge clk);
    {pin1, pin0} = pins;
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  initial begin
    do_reset(2'h0);
    chk({5'h0, oe, attn_n, irq}, 8'h02, "idle lines");
    cpu_rd(mailbox_pkg::ADDR_FLAGS, rd_val);
    chk(rd_val, 8'h00, "flags after reset");
    $display("reset test done");
    foreach (rows[i]) begin
      cpu_wr(mailbox_pkg::ADDR_CTRL, rows[i].wr);
      cpu_rd(mailbox_pkg::ADDR_CTRL, rd_val);
      chk({2'h0, ign, pe, pao, aux, prio}, {2'h0, rows[i].exp},
          "ctl");
      chk(rd_val, 8'h00, "control readback");
    end
    $display("control rows done");
    cpu_wr(8'h25, 8'hff);
    cpu_rd(8'h25, rd_val);
    chk(rd_val, 8'h00, "unmapped read");
    cpu_wr(mailbox_pkg::ADDR_CTRL, 8'h01);
    // both directions filled before anything is drained
    for (int i = 0; i < mailbox_pkg::NUM_DATA; i++) begin
      cpu_wr(8'(mailbox_pkg::ADDR_DATA0 + i), 8'(8'h10 + i));
      u_m.wr(2'(i), 8'(8'hc0 + i));
    end
    chk({6'h0, attn_n, irq}, 8'h01, "request lines");
    cpu_rd(mailbox_pkg::ADDR_FLAGS, rd_val);
    chk(rd_val, 8'hff, "all full");
    u_m.rd(mailbox_pkg::SEL_FLAGS, rd_val);
    chk(rd_val, 8'hff, "master flags read");
    cpu_rd(mailbox_pkg::ADDR_FLAGS, rd_val);
    chk(rd_val, 8'hff, "flags unchanged");
    for (int i = 0; i < mailbox_pkg::NUM_DATA; i++) begin
      u_m.rd(2'(i), rd_val);
      chk(rd_val, 8'(8'h10 + i), "master reads cpu byte");
      cpu_rd(8'(mailbox_pkg::ADDR_DATA0 + i), rd_val);
      chk(rd_val, 8'(8'hc0 + i), "cpu reads master byte");
    end
    chk({7'h0, oe}, 8'h00, "lines released");
    cpu_rd(mailbox_pkg::ADDR_FLAGS, rd_val);
    chk(rd_val, 8'h88, "drained flags");
    cpu_wr(mailbox_pkg::ADDR_FLAGS, 8'h77);
    cpu_rd(mailbox_pkg::ADDR_FLAGS, rd_val);
    chk(rd_val, 8'h08, "cpu status write");
    chk({7'h0, irq}, 8'h00, "request cleared");
    u_m.wr(mailbox_pkg::SEL_FLAGS, 8'hff);
    cpu_rd(mailbox_pkg::ADDR_FLAGS, rd_val);
    chk(rd_val, 8'h00, "master status write");
    chk({7'h0, attn_n}, 8'h01, "attention released");
    $display("data test done");
    do_reset(mailbox_pkg::PINS_COLD);
    chk({6'h0, cold, pe}, 8'h03, "cold boot entry");
    cpu_rd(mailbox_pkg::ADDR_CTRL, rd_val);
    chk(rd_val, 8'h20, "pins readback");
    u_m.wr(mailbox_pkg::SEL_DATA0, 8'ha5);
    chk(cmd_data, 8'ha5, "boot command");
    n_exec = 0;
    @(negedge clk);
    {pin1, pin0} = mailbox_pkg::PINS_START;
    repeat (8) @(negedge clk);
    chk({6'h0, cold, 1'b0}, 8'h00, "boot left");
    chk(8'(n_exec), 8'h01, "one start pulse");
    $display("cold boot test done");
    results();
  end
endmodule
